// [hdl/alt_input_route_select.sv]
// Alternative input route selector with its four select registers.
//
// What this block does
// - Each input picks one of two pins.
// - Input routing never touches pin output selection.
// - Select registers accessed only as whole bytes.
// - All select registers reset to 0x01.
// - Bit 7 picks interrupt 7 pin.
// - Bit 6 picks interrupt 6 pin.
// - Bit 5 picks second I2C pins.
// - Bit 4 picks first I2C pins.
// - Bit 3 reads zero, writes dropped.
// - Bit 2 picks third serial unit pins.
// - Bit 1 picks second serial unit pins.
// - Bit 0 picks first serial unit pins.
// - Low nibble picks pulse timers 0 and 1.
// - High nibble picks pulse timers 2 and 3.
// - Low nibble picks general timer 0 channels.
// - High nibble picks general timer 1 channels.
// - Low nibble picks general timer 2 channels.
// - Bit 4 picks first uart receive pin.
// - Bit 5 picks second uart receive pin.
// - Bits 7 and 6 read zero, writes ignored.
`timescale 1ns/1ps

module alt_input_route_select (
    // Clock and reset.
    input  wire logic                       clock,
    input  wire logic                       srst,
    // Register port.
    input  wire logic [31:0]                addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [7:0]                 rdata,
    // Port pin levels from the pads.
    input  wire input_route_pkg::port_pins_t pins,
    // Routed inputs toward the peripherals.
    output input_route_pkg::periph_in_t     periph
);

    // Per-bit two-way pick, one vector of selects at a time.
    function automatic logic [3:0] pick4(input logic [3:0] sel,
                                         input logic [3:0] a,
                                         input logic [3:0] b);
        pick4 = (a & ~sel) | (b & sel);
    endfunction

    // Single-bit two-way pick.
    function automatic logic pick(input logic sel,
                                  input logic a,
                                  input logic b);
        pick = sel ? b : a;
    endfunction

    // Pin synchroniser stages and routed output register.
    input_route_pkg::port_pins_t pins_m_q;
    input_route_pkg::port_pins_t pins_s_q;
    input_route_pkg::periph_in_t route_d;
    input_route_pkg::periph_in_t route_q;

    // Select registers and read data register.
    logic [7:0] sel_serial_q;
    logic [7:0] sel_pulse_q;
    logic [7:0] sel_general_q;
    logic [7:0] sel_uart_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Address decode, one hit line per register.
    wire hit_serial  = addr == input_route_pkg::ADDR_SERIAL_IRQ;
    wire hit_pulse   = addr == input_route_pkg::ADDR_PULSE_TIMERS;
    wire hit_general = addr == input_route_pkg::ADDR_GENERAL_TIMERS;
    wire hit_uart    = addr == input_route_pkg::ADDR_TIMER_UART;

    // The port carries only whole bytes, so partial updates cannot occur.
    wire wr_serial   = wr & hit_serial;
    wire wr_pulse    = wr & hit_pulse;
    wire wr_general  = wr & hit_general;
    wire wr_uart     = wr & hit_uart;

    // Unmapped addresses read back as zero.
    assign rdata_d =
        ({8{hit_serial}}  & sel_serial_q)  |
        ({8{hit_pulse}}   & sel_pulse_q)   |
        ({8{hit_general}} & sel_general_q) |
        ({8{hit_uart}}    & sel_uart_q);

    // Select registers; masked bits never store, so they read as zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            sel_serial_q  <= input_route_pkg::RST_SERIAL_IRQ;
            sel_pulse_q   <= input_route_pkg::RST_PULSE_TIMERS;
            sel_general_q <= input_route_pkg::RST_GENERAL_TIMERS;
            sel_uart_q    <= input_route_pkg::RST_TIMER_UART;
        end else begin
            if (wr_serial) begin
                sel_serial_q <= wdata &
                    input_route_pkg::WMASK_SERIAL_IRQ;
            end
            if (wr_pulse) begin
                sel_pulse_q <= wdata &
                    input_route_pkg::WMASK_PULSE_TIMERS;
            end
            if (wr_general) begin
                sel_general_q <= wdata &
                    input_route_pkg::WMASK_GENERAL_TIMERS;
            end
            if (wr_uart) begin
                sel_uart_q <= wdata &
                    input_route_pkg::WMASK_TIMER_UART;
            end
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rdata_d : 8'h00;
        end
    end

    assign rdata = rdata_q;

    // Pads are asynchronous, so every pin passes two flops first.
    always_ff @(posedge clock) begin
        if (srst) begin
            pins_m_q <= '0;
            pins_s_q <= '0;
        end else begin
            pins_m_q <= pins;
            pins_s_q <= pins_m_q;
        end
    end

    // Input routing only; pin output drivers are chosen elsewhere and
    // nothing here reaches them.
    assign route_d.ext_interrupt_7 = pick(
        sel_serial_q[input_route_pkg::BIT_IRQ7],
        pins_s_q.port5[0], pins_s_q.port8[4]);
    assign route_d.ext_interrupt_6 = pick(
        sel_serial_q[input_route_pkg::BIT_IRQ6],
        pins_s_q.port0[7], pins_s_q.port4[0]);
    assign route_d.i2c1_scl = pick(
        sel_serial_q[input_route_pkg::BIT_I2C1],
        pins_s_q.port2[1], pins_s_q.port3[1]);
    assign route_d.i2c1_sda = pick(
        sel_serial_q[input_route_pkg::BIT_I2C1],
        pins_s_q.port2[0], pins_s_q.port3[0]);
    assign route_d.i2c0_scl = pick(
        sel_serial_q[input_route_pkg::BIT_I2C0],
        pins_s_q.port1[7], pins_s_q.port6[4]);
    assign route_d.i2c0_sda = pick(
        sel_serial_q[input_route_pkg::BIT_I2C0],
        pins_s_q.port1[6], pins_s_q.port6[5]);

    // Clocked serial units: clock and data move together.
    assign route_d.serial_clock_in_2 = pick(
        sel_serial_q[input_route_pkg::BIT_SER2],
        pins_s_q.port8[2], pins_s_q.port9[6]);
    assign route_d.serial_data_in_2 = pick(
        sel_serial_q[input_route_pkg::BIT_SER2],
        pins_s_q.port8[0], pins_s_q.port9[4]);
    assign route_d.serial_clock_in_1 = pick(
        sel_serial_q[input_route_pkg::BIT_SER1],
        pins_s_q.port4[5], pins_s_q.port9[2]);
    assign route_d.serial_data_in_1 = pick(
        sel_serial_q[input_route_pkg::BIT_SER1],
        pins_s_q.port4[3], pins_s_q.port9[0]);
    assign route_d.serial_clock_in_0 = pick(
        sel_serial_q[input_route_pkg::BIT_SER0],
        pins_s_q.port4[2], pins_s_q.port10[7]);
    assign route_d.serial_data_in_0 = pick(
        sel_serial_q[input_route_pkg::BIT_SER0],
        pins_s_q.port4[0], pins_s_q.port10[5]);

    // Pulse timer captures; two channels share each alternate pin.
    assign route_d.pulse_capture_lo = pick4(
        sel_pulse_q[input_route_pkg::GRP_LO +: 4],
        pins_s_q.port6[3:0],
        {pins_s_q.port10[0], pins_s_q.port10[1],
         pins_s_q.port10[1], pins_s_q.port10[0]});
    assign route_d.pulse_capture_hi = pick4(
        sel_pulse_q[input_route_pkg::GRP_HI +: 4],
        {pins_s_q.port6[7], pins_s_q.port6[5],
         pins_s_q.port6[6], pins_s_q.port6[4]},
        {pins_s_q.port10[2], pins_s_q.port10[3],
         pins_s_q.port10[3], pins_s_q.port10[2]});

    // General timer captures, channel 1 in bit 0.
    assign route_d.general_capture_0 = pick4(
        sel_general_q[input_route_pkg::GRP_LO +: 4],
        pins_s_q.port2[3:0], pins_s_q.port13[3:0]);
    assign route_d.general_capture_1 = pick4(
        sel_general_q[input_route_pkg::GRP_HI +: 4],
        pins_s_q.port2[7:4], pins_s_q.port13[7:4]);
    assign route_d.general_capture_2 = pick4(
        sel_uart_q[input_route_pkg::GRP_LO +: 4],
        pins_s_q.port3[7:4],
        {pins_s_q.port6[3], pins_s_q.port6[7],
         pins_s_q.port6[6], pins_s_q.port6[1]});

    // Uart receive inputs.
    assign route_d.uart_receive_in_0 = pick(
        sel_uart_q[input_route_pkg::BIT_UART0],
        pins_s_q.port3[1], pins_s_q.port8[7]);
    assign route_d.uart_receive_in_1 = pick(
        sel_uart_q[input_route_pkg::BIT_UART1],
        pins_s_q.port3[3], pins_s_q.port5[6]);

    // Registered outputs keep mux glitches away from edge-sensitive
    // peripherals such as the interrupt detectors.
    always_ff @(posedge clock) begin
        if (srst) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    assign periph = route_q;

    // Reset leaves every select register at its reset value.
    a_reset_values:
    assert property (@(posedge clock)
        srst |=> (sel_serial_q == input_route_pkg::RST_SERIAL_IRQ) &&
                 (sel_pulse_q == input_route_pkg::RST_PULSE_TIMERS) &&
                 (sel_general_q == input_route_pkg::RST_GENERAL_TIMERS) &&
                 (sel_uart_q == input_route_pkg::RST_TIMER_UART))
    else $error("select register not 0x01 after reset");

    // A whole-byte write to the pulse timer register lands in full in the next cycle.
    a_byte_write:
    assert property (@(posedge clock) disable iff (srst)
        wr && hit_pulse |=> sel_pulse_q == $past(wdata))
    else $error("pulse select write not stored whole");

    // Reading returns the register held at the strobe, once only.
    a_read_back:
    assert property (@(posedge clock) disable iff (srst)
        rd && hit_general |=> rdata == $past(sel_general_q) ##1
        (rdata == 8'h00 || $past(rd)))
    else $error("general select read back wrong");

    // Reserved bit 3 never holds a one.
    a_rsv3_zero:
    assert property (@(posedge clock) disable iff (srst)
        wr && hit_serial |=> !sel_serial_q[input_route_pkg::BIT_RSV3] &&
        sel_serial_q[2:0] == $past(wdata[2:0]))
    else $error("reserved bit 3 stored a write");

    // Reserved bits 7 and 6 never hold a one.
    a_rsv76_zero:
    assert property (@(posedge clock) disable iff (srst)
        rd && hit_uart |=> rdata[7:6] == 2'b00)
    else $error("reserved bits 7 and 6 read non-zero");

    // A write to the timer and uart register keeps bits 7 and 6 clear.
    a_rsv76_store:
    assert property (@(posedge clock) disable iff (srst)
        wr && hit_uart |=> sel_uart_q[7:6] == 2'b00 &&
        sel_uart_q[5:0] == $past(wdata[5:0]))
    else $error("reserved bits 7 and 6 stored a write");

    // A stray write must not disturb a routing choice elsewhere.
    a_unmapped_quiet:
    assert property (@(posedge clock) disable iff (srst)
        wr && !(hit_serial || hit_pulse || hit_general || hit_uart) |=>
        $stable(sel_serial_q) && $stable(sel_pulse_q) &&
        $stable(sel_general_q) && $stable(sel_uart_q))
    else $error("unmapped write changed a select register");

    // Interrupt 7 follows the selected pin one cycle on.
    a_irq7_route:
    assert property (@(posedge clock) disable iff (srst)
        1'b1 |=> route_q.ext_interrupt_7 == ($past(sel_serial_q[7]) ?
            $past(pins_s_q.port8[4]) : $past(pins_s_q.port5[0])))
    else $error("interrupt 7 taken from wrong pin");

    // Interrupt 6 follows the selected pin one cycle on.
    a_irq6_route:
    assert property (@(posedge clock) disable iff (srst)
        1'b1 |=> route_q.ext_interrupt_6 == ($past(sel_serial_q[6]) ?
            $past(pins_s_q.port4[0]) : $past(pins_s_q.port0[7])))
    else $error("interrupt 6 taken from wrong pin");

    // Second I2C data line on the selected pin.
    a_i2c1_route:
    assert property (@(posedge clock) disable iff (srst)
        sel_serial_q[5] |=> route_q.i2c1_sda == $past(pins_s_q.port3[0]))
    else $error("second I2C data from wrong pin");

    // First I2C clock line on the selected pin.
    a_i2c0_route:
    assert property (@(posedge clock) disable iff (srst)
        !sel_serial_q[4] |=> route_q.i2c0_scl == $past(pins_s_q.port1[7]))
    else $error("first I2C clock from wrong pin");

    // Third serial unit clock on the selected pin.
    a_ser2_route:
    assert property (@(posedge clock) disable iff (srst)
        sel_serial_q[2] |=>
        route_q.serial_clock_in_2 == $past(pins_s_q.port9[6]))
    else $error("third serial clock from wrong pin");

    // Second serial unit data on the selected pin.
    a_ser1_route:
    assert property (@(posedge clock) disable iff (srst)
        !sel_serial_q[1] |=>
        route_q.serial_data_in_1 == $past(pins_s_q.port4[3]))
    else $error("second serial data from wrong pin");

    // First serial unit data on the selected pin.
    a_ser0_route:
    assert property (@(posedge clock) disable iff (srst)
        sel_serial_q[0] |=>
        route_q.serial_data_in_0 == $past(pins_s_q.port10[5]))
    else $error("first serial data from wrong pin");

    // Pulse unit 1 channel 1 shares its alternate pin with unit 0.
    a_pulse_lo:
    assert property (@(posedge clock) disable iff (srst)
        sel_pulse_q[3] |=>
        route_q.pulse_capture_lo[3] == $past(pins_s_q.port10[0]))
    else $error("pulse unit 1 channel 1 from wrong pin");

    // Pulse unit 3 channel 0 sits on its crossed default pin.
    a_pulse_hi:
    assert property (@(posedge clock) disable iff (srst)
        !sel_pulse_q[6] |=>
        route_q.pulse_capture_hi[2] == $past(pins_s_q.port6[5]))
    else $error("pulse unit 3 channel 0 from wrong pin");

    // General timer 0 channel 4 on the selected pin.
    a_gen0_route:
    assert property (@(posedge clock) disable iff (srst)
        sel_general_q[3] |=>
        route_q.general_capture_0[3] == $past(pins_s_q.port13[3]))
    else $error("general timer 0 channel 4 from wrong pin");

    // General timer 1 channel 1 on the selected pin.
    a_gen1_route:
    assert property (@(posedge clock) disable iff (srst)
        !sel_general_q[4] |=>
        route_q.general_capture_1[0] == $past(pins_s_q.port2[4]))
    else $error("general timer 1 channel 1 from wrong pin");

    // General timer 2 channel 2 on its alternate pin.
    a_gen2_route:
    assert property (@(posedge clock) disable iff (srst)
        sel_uart_q[1] |=>
        route_q.general_capture_2[1] == $past(pins_s_q.port6[6]))
    else $error("general timer 2 channel 2 from wrong pin");

    // First uart receive on the selected pin.
    a_uart0_route:
    assert property (@(posedge clock) disable iff (srst)
        1'b1 |=> route_q.uart_receive_in_0 == ($past(sel_uart_q[4]) ?
            $past(pins_s_q.port8[7]) : $past(pins_s_q.port3[1])))
    else $error("first uart receive from wrong pin");

    // Second uart receive on the selected pin.
    a_uart1_route:
    assert property (@(posedge clock) disable iff (srst)
        1'b1 |=> route_q.uart_receive_in_1 == ($past(sel_uart_q[5]) ?
            $past(pins_s_q.port5[6]) : $past(pins_s_q.port3[3])))
    else $error("second uart receive from wrong pin");

    // An unselected pin toggling alone leaves the output still.
    a_unsel_quiet:
    assert property (@(posedge clock) disable iff (srst)
        !sel_serial_q[7] && $stable(sel_serial_q) &&
        $stable(pins_s_q.port5[0]) && $changed(pins_s_q.port8[4])
        |=> $stable(route_q.ext_interrupt_7))
    else $error("unselected pin disturbed interrupt 7");

endmodule // alt_input_route_select

// [pkg/input_route_pkg.sv]
// Constants and carrier types of the alternative input route selector.
package input_route_pkg;

    // Number of select registers and their data width.
    localparam int SEL_COUNT = 4;
    localparam int SEL_WIDTH = 8;

    // Register indices into the select array.
    localparam int IDX_SERIAL_IRQ     = 0;
    localparam int IDX_PULSE_TIMERS   = 1;
    localparam int IDX_GENERAL_TIMERS = 2;
    localparam int IDX_TIMER_UART     = 3;

    // Byte addresses of the four select registers.
    localparam logic [31:0] ADDR_SERIAL_IRQ     = 32'hfffff720;
    localparam logic [31:0] ADDR_PULSE_TIMERS   = 32'hfffff722;
    localparam logic [31:0] ADDR_GENERAL_TIMERS = 32'hfffff724;
    localparam logic [31:0] ADDR_TIMER_UART     = 32'hfffff726;

    // Reset values, one per register.
    localparam logic [7:0] RST_SERIAL_IRQ     = 8'h01;
    localparam logic [7:0] RST_PULSE_TIMERS   = 8'h01;
    localparam logic [7:0] RST_GENERAL_TIMERS = 8'h01;
    localparam logic [7:0] RST_TIMER_UART     = 8'h01;

    // Writable bits; cleared bits are fixed at zero.
    localparam logic [7:0] WMASK_SERIAL_IRQ     = 8'hf7;
    localparam logic [7:0] WMASK_PULSE_TIMERS   = 8'hff;
    localparam logic [7:0] WMASK_GENERAL_TIMERS = 8'hff;
    localparam logic [7:0] WMASK_TIMER_UART     = 8'h3f;

    // Field positions in the serial and interrupt select register.
    localparam int BIT_IRQ7 = 7;
    localparam int BIT_IRQ6 = 6;
    localparam int BIT_I2C1 = 5;
    localparam int BIT_I2C0 = 4;
    localparam int BIT_RSV3 = 3;
    localparam int BIT_SER2 = 2;
    localparam int BIT_SER1 = 1;
    localparam int BIT_SER0 = 0;

    // Field positions of the four-bit timer groups.
    localparam int GRP_LO = 0;
    localparam int GRP_HI = 4;

    // Field positions in the timer and uart select register.
    localparam int BIT_UART1 = 5;
    localparam int BIT_UART0 = 4;

    // Port pin groups that can feed a routed input.
    typedef struct packed {
        logic [7:0] port13;
        logic [7:0] port10;
        logic [7:0] port9;
        logic [7:0] port8;
        logic [7:0] port6;
        logic [7:0] port5;
        logic [7:0] port4;
        logic [7:0] port3;
        logic [7:0] port2;
        logic [7:0] port1;
        logic [7:0] port0;
    } port_pins_t;

    // Routed inputs handed to the peripherals.
    typedef struct packed {
        logic       ext_interrupt_7;
        logic       ext_interrupt_6;
        logic       i2c1_scl;
        logic       i2c1_sda;
        logic       i2c0_scl;
        logic       i2c0_sda;
        logic       serial_clock_in_2;
        logic       serial_data_in_2;
        logic       serial_clock_in_1;
        logic       serial_data_in_1;
        logic       serial_clock_in_0;
        logic       serial_data_in_0;
        logic [3:0] pulse_capture_lo;
        logic [3:0] pulse_capture_hi;
        logic [3:0] general_capture_0;
        logic [3:0] general_capture_1;
        logic [3:0] general_capture_2;
        logic       uart_receive_in_1;
        logic       uart_receive_in_0;
    } periph_in_t;

endpackage

// [verification/pad_model.sv]
// Behavioural model of the port pads that feed the input route selector.
`timescale 1ns/1ps

module pad_model (
    // Pattern selection from the bench.
    input  wire logic [2:0]                  code,
    // Pad levels toward the selector.
    output input_route_pkg::port_pins_t      pins
);

    logic [87:0] flat;

    // Under codes 0 to 5 each group gets a byte that differs from every other group, so two
    // candidate pins of one input disagree under at least one pattern, except general_capture_0 bits 0 to 2, where port2 and port13 always match.
    always_comb begin
        for (int g = 0; g < 11; g++) begin
            if (code == 3'h6) begin
                flat[g*8 +: 8] = 8'h00;
            end else if (code == 3'h7) begin
                flat[g*8 +: 8] = 8'hff;
            end else begin
                flat[g*8 +: 8] = 8'(code) * 8'h1d + 8'(g) * 8'h37;
            end
        end
    end

    // Pads are plain levels with no release state in this model.
    assign pins = flat;

endmodule // pad_model

// [verification/tb.sv]
// Self-checking testbench for the alternative input route selector.
`timescale 1ns/1ps

`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
end

module tb;

    logic                         clock;
    logic                         srst;
    logic [31:0]                  addr;
    logic [7:0]                   wdata;
    logic                         wr;
    logic                         rd;
    logic [7:0]                   rdata;
    logic [2:0]                   code;
    input_route_pkg::port_pins_t  pins;
    input_route_pkg::periph_in_t  periph;
    int                           err_count;
    int                           n_compared;
    logic [31:0]                  adr [4];
    logic [7:0]                   sv [4];
    logic [7:0]                   wm [4];
    logic [7:0]                   pats [6];

    // Clock at 250 MHz.
    always #2 clock = ~clock;

    pad_model pads (
        .code (code),
        .pins (pins)
    );

    alt_input_route_select DUT (
        .clock  (clock),
        .srst   (srst),
        .addr   (addr),
        .wdata  (wdata),
        .wr     (wr),
        .rd     (rd),
        .rdata  (rdata),
        .pins   (pins),
        .periph (periph)
    );

    // Expected routing, written out pin by pin from the select fields.
    function automatic input_route_pkg::periph_in_t route(
        input input_route_pkg::port_pins_t p,
        input logic [7:0] s0, input logic [7:0] s1,
        input logic [7:0] s2, input logic [7:0] s3);
        input_route_pkg::periph_in_t r;
        r.ext_interrupt_7   = s0[7] ? p.port8[4]  : p.port5[0];
        r.ext_interrupt_6   = s0[6] ? p.port4[0]  : p.port0[7];
        r.i2c1_scl          = s0[5] ? p.port3[1]  : p.port2[1];
        r.i2c1_sda          = s0[5] ? p.port3[0]  : p.port2[0];
        r.i2c0_scl          = s0[4] ? p.port6[4]  : p.port1[7];
        r.i2c0_sda          = s0[4] ? p.port6[5]  : p.port1[6];
        r.serial_clock_in_2 = s0[2] ? p.port9[6]  : p.port8[2];
        r.serial_data_in_2  = s0[2] ? p.port9[4]  : p.port8[0];
        r.serial_clock_in_1 = s0[1] ? p.port9[2]  : p.port4[5];
        r.serial_data_in_1  = s0[1] ? p.port9[0]  : p.port4[3];
        r.serial_clock_in_0 = s0[0] ? p.port10[7] : p.port4[2];
        r.serial_data_in_0  = s0[0] ? p.port10[5] : p.port4[0];
        r.pulse_capture_lo[0] = s1[0] ? p.port10[0] : p.port6[0];
        r.pulse_capture_lo[1] = s1[1] ? p.port10[1] : p.port6[1];
        r.pulse_capture_lo[2] = s1[2] ? p.port10[1] : p.port6[2];
        r.pulse_capture_lo[3] = s1[3] ? p.port10[0] : p.port6[3];
        r.pulse_capture_hi[0] = s1[4] ? p.port10[2] : p.port6[4];
        r.pulse_capture_hi[1] = s1[5] ? p.port10[3] : p.port6[6];
        r.pulse_capture_hi[2] = s1[6] ? p.port10[3] : p.port6[5];
        r.pulse_capture_hi[3] = s1[7] ? p.port10[2] : p.port6[7];
        for (int i = 0; i < 4; i++) begin
            r.general_capture_0[i] = s2[i] ? p.port13[i] : p.port2[i];
            r.general_capture_1[i] = s2[i+4] ? p.port13[i+4]
                                             : p.port2[i+4];
        end
        r.general_capture_2[0] = s3[0] ? p.port6[1] : p.port3[4];
        r.general_capture_2[1] = s3[1] ? p.port6[6] : p.port3[5];
        r.general_capture_2[2] = s3[2] ? p.port6[7] : p.port3[6];
        r.general_capture_2[3] = s3[3] ? p.port6[3] : p.port3[7];
        r.uart_receive_in_0    = s3[4] ? p.port8[7] : p.port3[1];
        r.uart_receive_in_1    = s3[5] ? p.port5[6] : p.port3[3];
        return r;
    endfunction

    // One-cycle write strobe; the gap edge keeps strobes from doubling.
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data are looked at in the following cycle.
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // Verdict and end of run.
    task automatic close_out;
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        close_out();
    end

    // Main sequence.
    initial begin
        clock = 1'b0;
        srst  = 1'b1;
        addr  = 32'h00000000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        code  = 3'h0;
        err_count  = 0;
        n_compared = 0;
        adr  = '{32'hfffff720, 32'hfffff722, 32'hfffff724, 32'hfffff726};
        wm   = '{8'hf7, 8'hff, 8'hff, 8'h3f};
        pats = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h0f, 8'hf0};
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) rd_chk(adr[i], 8'h01);
        // Reserved bits must come back zero after an all-ones write.
        for (int i = 0; i < 4; i++) begin
            wr_reg(adr[i], 8'hff);
            rd_chk(adr[i], wm[i]);
        end
        // Read data stand for one cycle only.
        @(posedge clock);
        #1;
        `CHK(rdata, 8'h00)
        // Unmapped odd byte and an address past the block are refused.
        wr_reg(32'hfffff721, 8'h00);
        wr_reg(32'hfffff728, 8'h00);
        rd_chk(32'hfffff721, 8'h00);
        rd_chk(adr[0], 8'hf7);
        // Every select pattern against every pad pattern.
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 4; i++) begin
                sv[i] = pats[k] ^ (8'(i) * 8'h33);
                wr_reg(adr[i], sv[i]);
            end
            for (int c = 0; c < 8; c++) begin
                @(posedge clock);
                code <= 3'(c);
                repeat (5) @(posedge clock);
                #1;
                `CHK(periph, route(pins, sv[0], sv[1], sv[2], sv[3]))
            end
        end
        // Pin to peripheral delay is three edges through the syncs.
        wr_reg(adr[0], 8'h00);
        @(posedge clock);
        code <= 3'h6;
        repeat (5) @(posedge clock);
        code <= 3'h7;
        repeat (2) @(posedge clock);
        #1;
        `CHK(periph.ext_interrupt_7, 1'b0)
        @(posedge clock);
        #1;
        `CHK(periph.ext_interrupt_7, 1'b1)
        // A reset in mid-run must bring every select back, not only at power-up.
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) rd_chk(adr[i], 8'h01);
        close_out();
    end

endmodule // tb
